// File: hdl/kpc_pkg.sv
// What this block does
// - Scan port input mode enables pull-downs
// - Key pin pull-down when option bit set
// - Transmit indicator low while carrier emitted
// - Low-voltage reset drives transmit indicator low
// - Rotate-left loads serial input or bit 3
// - Serial input high impedance when deselected
// - Ports reached as port registers
// - Control bit 1 sets scan direction
// - Control bit 2 runs transmit timer
// - Control bit 3 selects carrier divide
// - Control bits 4,5 give pointer high bits
// - Control bit 6 chooses stop on halt
// - Reset clears control bits 0,8,9
// - Standby stops execution, keeps state
// - Stop waits for timer down-count zero
// - Halt operand selects wake source, level
// - Serial wake always if rotate source A3
// - All-clear pin low resets processor
// - Mask option picks divide-12 carrier duty
// - Hang-up option resets in stop mode
// - Unused wake source in halt resets
package kpc_pkg;
  // ----------------------------------------
  // Port register selects
  // ----------------------------------------
  localparam logic [1:0] PORT_SCAN = 2'h0;
  localparam logic [1:0] PORT_CTRL = 2'h1;
  localparam logic [1:0] PORT_KEY = 2'h2;
  // ----------------------------------------
  // Control register fields
  // ----------------------------------------
  localparam int CTRL_WIDTH = 10;
  localparam int BIT_ROT_SERIAL = 0;
  localparam int BIT_SCAN_OUT = 1;
  localparam int BIT_TIMER_RUN = 2;
  localparam int BIT_DIV12 = 3;
  localparam int BIT_PTR_LO = 4;
  localparam int BIT_PTR_HI = 5;
  localparam int BIT_OSC_STOP = 6;
  localparam logic [9:0] CTRL_RESET = 10'h000;
  localparam logic [9:0] CTRL_CLEAR_MASK = 10'h301;
  // ----------------------------------------
  // Halt operand codes
  // ----------------------------------------
  localparam logic [2:0] WAKE_SERIAL = 3'h0;
  localparam logic [2:0] WAKE_SCAN = 3'h1;
  localparam logic [2:0] WAKE_KEY = 3'h2;
  localparam logic [2:0] WAKE_TIMER = 3'h3;
  // ----------------------------------------
  // Carrier timing
  // ----------------------------------------
  localparam logic [3:0] DIV8_TERM = 4'h7;
  localparam logic [3:0] DIV12_TERM = 4'hb;
  localparam logic [3:0] DIV8_HIGH = 4'h4;
  localparam logic [3:0] DIV12_HALF = 4'h6;
  localparam logic [3:0] DIV12_THIRD = 4'h4;
  localparam logic [3:0] TICK_TERM = 4'h7;
  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_HALT = 2'b01,
    ST_STOP_WAIT = 2'b10,
    ST_STOP = 2'b11
  } kpc_state_type;
  typedef struct packed {
    logic key_pulldown_en_3;
    logic key_pulldown_en_2;
    logic key_pulldown_en_1;
    logic key_pulldown_en_0;
    logic third_duty;
    logic serial_pulldown;
    logic all_key_hangup_option;
    logic unused_serial;
    logic unused_scan;
    logic unused_key;
  } kpc_mask_type;
  typedef struct packed {
    logic halt;
    logic [3:0] operand;
  } kpc_halt_type;
endpackage

// File: hdl/kpc_sync.sv
`timescale 1ns/1ps
// Two-flop synchroniser for a bundle of pin inputs
module kpc_sync #(
  parameter int WIDTH = 13
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] pin_sync
);
  // First stage, read only by the second
  logic [WIDTH-1:0] meta;
  // ----------------------------------------
  // Synchroniser chain
  // ----------------------------------------
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      meta <= '0;
      pin_sync <= '0;
    end else begin
      meta <= pin_in;
      pin_sync <= meta;
    end
  end
endmodule

// File: hdl/kpc_top.sv
`timescale 1ns/1ps
// Port, control and standby logic
module kpc_top (
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Internal low-voltage reset request
  input wire logic low_voltage_reset,
  // All-clear pin, active low
  input wire logic all_clear_pin_n,
  // Mask option switches
  input wire kpc_pkg::kpc_mask_type mask_option,
  // Port register access from the core
  input wire logic [1:0] port_sel,
  input wire logic port_write,
  input wire logic [9:0] port_wdata,
  output logic [9:0] port_rdata,
  // Rotate-left instruction
  input wire logic rotate_left_instruction,
  input wire logic [3:0] acc_in,
  output logic [3:0] acc_out,
  output logic acc_out_valid,
  // Halt instruction
  input wire kpc_pkg::kpc_halt_type halt_req,
  // Timer status from the down-counter
  input wire logic timer_nonzero,
  input wire logic carrier_enable,
  // Pins
  input wire logic [7:0] scan_io_port_in,
  output logic [7:0] scan_io_port_out,
  output logic [7:0] scan_io_port_oe,
  output logic [7:0] scan_io_port_pulldown,
  input wire logic [3:0] key_input_pins,
  output logic [3:0] key_pulldown,
  input wire logic serial_in,
  output logic serial_in_enable,
  output logic serial_pulldown,
  output logic carrier_output,
  output logic transmit_indicator,
  // Core status
  output logic [1:0] rom_ptr_high,
  output logic timer_run,
  output logic exec_enable,
  output logic osc_running,
  output logic core_reset
);
  // ----------------------------------------
  // Synchronised pins
  // ----------------------------------------
  logic [12:0] pins_sync; // Scan, key, serial
  logic [7:0] scan_s;
  logic [3:0] key_s;
  logic serial_s;
  logic clear_s; // All-clear request, active high
  // Clear is sensed inverted so the synchroniser's zero reset reads as idle,
  // otherwise a false all-clear would follow every system reset
  kpc_sync #(.WIDTH(14)) u_sync (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .pin_in({!all_clear_pin_n, serial_in, key_input_pins, scan_io_port_in}),
    .pin_sync({clear_s, pins_sync})
  );
  assign scan_s = pins_sync[7:0];
  assign key_s = pins_sync[11:8];
  assign serial_s = pins_sync[12];

  // Any internal reset that restarts the core
  logic soft_reset; // Hang-up or unused-wake reset
  logic any_reset;
  assign any_reset = clear_s || low_voltage_reset || soft_reset;

  // Standby state, read by the port logic below
  kpc_pkg::kpc_state_type state;
  kpc_pkg::kpc_state_type next_state;

  // ----------------------------------------
  // Control and scan latch
  // ----------------------------------------
  logic [9:0] ctrl; // Control register
  logic [7:0] scan_latch; // Scan output latch
  // Only bits 0, 8, 9 have a defined reset; others kept low for determinism
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl <= kpc_pkg::CTRL_RESET;
    end else if (any_reset) begin
      ctrl <= ctrl & ~kpc_pkg::CTRL_CLEAR_MASK;
    end else if (port_write && port_sel == kpc_pkg::PORT_CTRL && state == kpc_pkg::ST_RUN) begin
      ctrl <= port_wdata;
    end
  end

  // Scan output latch, written in either mode
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      scan_latch <= 8'h00;
    end else if (port_write && port_sel == kpc_pkg::PORT_SCAN && state == kpc_pkg::ST_RUN) begin
      scan_latch <= port_wdata[7:0];
    end
  end

  // ----------------------------------------
  // Port read data
  // ----------------------------------------
  // Reads return pin levels regardless of direction
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      port_rdata <= 10'h000;
    end else begin
      unique case (port_sel)
        kpc_pkg::PORT_SCAN: port_rdata <= {2'h0, scan_s};
        kpc_pkg::PORT_CTRL: port_rdata <= ctrl;
        kpc_pkg::PORT_KEY: port_rdata <= {6'h00, key_s};
        default: port_rdata <= 10'h000; // Unused select
      endcase
    end
  end

  // ----------------------------------------
  // Pin drivers and pull-downs
  // ----------------------------------------
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      scan_io_port_out <= 8'h00;
      scan_io_port_oe <= 8'h00;
      scan_io_port_pulldown <= 8'hff;
      key_pulldown <= 4'h0;
      serial_in_enable <= 1'b0;
      serial_pulldown <= 1'b0;
      rom_ptr_high <= 2'h0;
      timer_run <= 1'b0;
    end else begin
      scan_io_port_out <= scan_latch;
      scan_io_port_oe <= {8{ctrl[kpc_pkg::BIT_SCAN_OUT]}};
      scan_io_port_pulldown <= {8{!ctrl[kpc_pkg::BIT_SCAN_OUT]}};
      key_pulldown <= {mask_option.key_pulldown_en_3, mask_option.key_pulldown_en_2,
                       mask_option.key_pulldown_en_1, mask_option.key_pulldown_en_0};
      // No through-current: input buffer off unless serial mode
      serial_in_enable <= ctrl[kpc_pkg::BIT_ROT_SERIAL] && !any_reset;
      serial_pulldown <= ctrl[kpc_pkg::BIT_ROT_SERIAL] && !any_reset && mask_option.serial_pulldown;
      rom_ptr_high <= {ctrl[kpc_pkg::BIT_PTR_HI], ctrl[kpc_pkg::BIT_PTR_LO]};
      timer_run <= ctrl[kpc_pkg::BIT_TIMER_RUN] && !any_reset;
    end
  end

  // ----------------------------------------
  // Rotate-left bit 0 source
  // ----------------------------------------
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      acc_out <= 4'h0;
      acc_out_valid <= 1'b0;
    end else begin
      acc_out_valid <= rotate_left_instruction && state == kpc_pkg::ST_RUN;
      if (rotate_left_instruction && state == kpc_pkg::ST_RUN) begin
        acc_out <= {acc_in[2:0], ctrl[kpc_pkg::BIT_ROT_SERIAL] ? serial_s : acc_in[3]};
      end
    end
  end

  // ----------------------------------------
  // Carrier generator
  // ----------------------------------------
  logic [3:0] div_count; // Oscillator phase count
  logic [3:0] div_term;
  logic [3:0] div_high; // Cycles the carrier stays high
  logic carrier_on;
  assign div_term = ctrl[kpc_pkg::BIT_DIV12] ? kpc_pkg::DIV12_TERM : kpc_pkg::DIV8_TERM;
  // Duty option matters only at divide-by-12
  assign div_high = !ctrl[kpc_pkg::BIT_DIV12] ? kpc_pkg::DIV8_HIGH :
                    (mask_option.third_duty ? kpc_pkg::DIV12_THIRD : kpc_pkg::DIV12_HALF);
  assign carrier_on = carrier_enable && timer_nonzero && osc_running;

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      div_count <= 4'h0;
    end else if (!osc_running || div_count >= div_term) begin
      div_count <= 4'h0;
    end else begin
      div_count <= div_count + 4'h1;
    end
  end

  // Carrier and indicator move together from the same flop edge
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      carrier_output <= 1'b0;
      transmit_indicator <= 1'b1;
    end else if (low_voltage_reset) begin
      carrier_output <= 1'b0;
      transmit_indicator <= 1'b0;
    end else if (any_reset) begin
      carrier_output <= 1'b0;
      transmit_indicator <= 1'b1;
    end else begin
      carrier_output <= carrier_on && div_count < div_high;
      transmit_indicator <= !carrier_on;
    end
  end

  // ----------------------------------------
  // Standby state machine
  // ----------------------------------------
  logic [3:0] wake_code; // Latched halt operand
  logic wake_hit;
  logic level;
  logic scan_input_mode;
  assign level = wake_code[3];
  assign scan_input_mode = !ctrl[kpc_pkg::BIT_SCAN_OUT];

  // Wake condition from the latched operand
  always_comb begin
    wake_hit = 1'b0;
    if (!wake_code[2]) begin
      unique case (wake_code[1:0])
        2'h0: wake_hit = !ctrl[kpc_pkg::BIT_ROT_SERIAL] || (serial_s == level);
        2'h1: wake_hit = scan_input_mode && (level ? |scan_s : ~&scan_s);
        2'h2: wake_hit = level ? |key_s : ~&key_s;
        2'h3: wake_hit = !level && !timer_nonzero;
      endcase
    end
  end

  // Next standby state
  always_comb begin
    next_state = state;
    unique case (state)
      kpc_pkg::ST_RUN: begin
        if (halt_req.halt) begin
          if (!ctrl[kpc_pkg::BIT_OSC_STOP]) begin
            next_state = kpc_pkg::ST_HALT;
          end else if (timer_nonzero) begin
            next_state = kpc_pkg::ST_STOP_WAIT;
          end else begin
            next_state = kpc_pkg::ST_STOP;
          end
        end
      end
      kpc_pkg::ST_HALT: begin
        if (wake_hit) begin
          next_state = kpc_pkg::ST_RUN;
        end
      end
      kpc_pkg::ST_STOP_WAIT: begin
        if (wake_hit) begin
          next_state = kpc_pkg::ST_RUN;
        end else if (!timer_nonzero) begin
          next_state = kpc_pkg::ST_STOP;
        end
      end
      kpc_pkg::ST_STOP: begin
        if (wake_hit) begin
          next_state = kpc_pkg::ST_RUN;
        end
      end
    endcase
  end

  // State and operand latch; reset returns to run
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= kpc_pkg::ST_RUN;
      wake_code <= 4'h0;
    end else if (any_reset) begin
      state <= kpc_pkg::ST_RUN;
    end else begin
      state <= next_state;
      if (state == kpc_pkg::ST_RUN && halt_req.halt) begin
        wake_code <= halt_req.operand;
      end
    end
  end

  // ----------------------------------------
  // Self reset from mask options
  // ----------------------------------------
  logic in_standby;
  logic unused_hit;
  assign in_standby = state != kpc_pkg::ST_RUN;
  // Unused wake sources: only a high level on an unused input counts, a low level never does
  assign unused_hit = (mask_option.unused_serial && ctrl[kpc_pkg::BIT_ROT_SERIAL] && serial_s) ||
                      (mask_option.unused_scan && scan_input_mode && |scan_s) ||
                      (mask_option.unused_key && |key_s);

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      soft_reset <= 1'b0;
    end else begin
      soft_reset <= (in_standby && unused_hit) ||
                    (state == kpc_pkg::ST_STOP && mask_option.all_key_hangup_option &&
                     (scan_input_mode || ~&scan_s));
    end
  end

  // ----------------------------------------
  // Core status outputs
  // ----------------------------------------
  // Execution frozen in standby; registers simply hold
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      exec_enable <= 1'b0;
      osc_running <= 1'b1;
      core_reset <= 1'b1;
    end else begin
      exec_enable <= next_state == kpc_pkg::ST_RUN && !any_reset;
      osc_running <= next_state != kpc_pkg::ST_STOP || any_reset;
      core_reset <= any_reset;
    end
  end
endmodule

// File: dv/kpc_top_props.sv
`timescale 1ns/1ps
// ----------------------------------------
// Port, control and standby checks
// ----------------------------------------
module kpc_top_props (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic low_voltage_reset,
  input wire logic all_clear_pin_n,
  input wire kpc_pkg::kpc_mask_type mask_option,
  input wire logic [1:0] port_sel,
  input wire logic port_write,
  input wire logic [9:0] port_wdata,
  input wire logic rotate_left_instruction,
  input wire logic [3:0] acc_in,
  input wire logic [3:0] acc_out,
  input wire logic acc_out_valid,
  input wire kpc_pkg::kpc_halt_type halt_req,
  input wire logic timer_nonzero,
  input wire logic carrier_output,
  input wire logic transmit_indicator,
  input wire logic [7:0] scan_io_port_oe,
  input wire logic [7:0] scan_io_port_pulldown,
  input wire logic [3:0] key_pulldown,
  input wire logic [1:0] rom_ptr_high,
  input wire logic timer_run,
  input wire logic exec_enable,
  input wire logic osc_running,
  input wire logic core_reset
);
  // One domain, so clock and reset are given once
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (sys_rst);
  scan_pulldown_a: assert property (scan_io_port_pulldown == ~scan_io_port_oe)
    else $error("scan pull-down not opposite to drive");
  key_pulldown_a: assert property ($past(!sys_rst) |-> key_pulldown == $past(mask_option[9:6]))
    else $error("key pull-down differs from option");
  tx_busy_a: assert property (carrier_output |-> !transmit_indicator)
    else $error("indicator high while carrier out");
  low_volt_a: assert property (low_voltage_reset [*2] |-> !transmit_indicator)
    else $error("indicator high in low-voltage reset");
  rotate_upper_a: assert property (rotate_left_instruction && exec_enable |=>
    acc_out_valid && acc_out[3:1] == $past(acc_in[2:0]))
    else $error("rotate result wrong");
  ctrl_fields_a: assert property (port_write && port_sel == kpc_pkg::PORT_CTRL && exec_enable |-> ##2
    (scan_io_port_oe == {8{$past(port_wdata[1], 2)}} && timer_run == $past(port_wdata[2], 2)
    && rom_ptr_high == $past(port_wdata[5:4], 2)))
    else $error("control fields not applied");
  halt_stops_a: assert property (halt_req.halt && exec_enable |=> !exec_enable)
    else $error("execution goes on after halt");
  stop_wait_a: assert property (!exec_enable && timer_nonzero |-> osc_running)
    else $error("oscillator stopped while timer counts");
  all_clear_a: assert property (!all_clear_pin_n [*5] |-> core_reset)
    else $error("all-clear gives no core reset");
  cover property (rotate_left_instruction && exec_enable);
  cover property (halt_req.halt && exec_enable);
  cover property (!exec_enable && !osc_running);
endmodule

bind kpc_top kpc_top_props u_props (.*);

// File: dv/kpc_keypad_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// Key matrix and serial source at the pins
// ----------------------------------------
module kpc_keypad_model (
  input wire logic sys_clk,
  input wire logic [7:0] scan_out,
  input wire logic [7:0] scan_oe,
  input wire logic [7:0] scan_pd,
  input wire logic serial_en,
  input wire logic [7:0] press,
  input wire logic ser_bit,
  output logic [7:0] scan_in,
  output logic serial_in
);
  logic flip = 1'b0; // Floating level, never steady
  // Toggles so an undriven pin cannot pass for a held value
  always_ff @(posedge sys_clk) flip <= ~flip;
  // Driver wins, then a closed key, then the pull-down
  always_comb begin
    for (int b = 0; b < 8; b++) begin
      if (scan_oe[b]) scan_in[b] = scan_out[b];
      else if (press[b]) scan_in[b] = 1'b1;
      else if (scan_pd[b]) scan_in[b] = 1'b0;
      else scan_in[b] = flip;
    end
  end
  // Source only reaches the pin while it is enabled
  assign serial_in = serial_en ? ser_bit : flip;
endmodule

// File: dv/kpc_top_tb.sv
`timescale 1ns/1ps
// ----------------------------------------
// Bench for port, control and standby logic
// ----------------------------------------
module kpc_top_tb;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic low_voltage_reset = 1'b0;
  logic all_clear_pin_n = 1'b1;
  kpc_pkg::kpc_mask_type mask_option = 10'h3d0; // Key and serial pull-downs fitted
  logic [1:0] port_sel = 2'h0;
  logic port_write = 1'b0;
  logic [9:0] port_wdata = 10'h000;
  logic [9:0] port_rdata;
  logic rotate_left_instruction = 1'b0;
  logic [3:0] acc_in = 4'h0;
  logic [3:0] acc_out, key_pulldown;
  kpc_pkg::kpc_halt_type halt_req = 5'h00;
  logic timer_nonzero = 1'b0;
  logic carrier_enable = 1'b0;
  logic [7:0] scan_io_port_in, scan_io_port_out, scan_io_port_oe, scan_io_port_pulldown;
  logic [3:0] key_input_pins = 4'h0;
  logic acc_out_valid, serial_in, serial_in_enable, serial_pulldown, carrier_output, transmit_indicator;
  logic [1:0] rom_ptr_high;
  logic timer_run, exec_enable, osc_running, core_reset;
  logic [7:0] press = 8'h00; // Closed keys on the scan lines
  logic ser_bit = 1'b0; // Serial source level
  int miscompares = 0;
  int checks = 0;
  kpc_top dut (.*);
  kpc_keypad_model partner (.sys_clk(sys_clk), .scan_out(scan_io_port_out), .scan_oe(scan_io_port_oe),
    .scan_pd(scan_io_port_pulldown), .serial_en(serial_in_enable), .press(press), .ser_bit(ser_bit),
    .scan_in(scan_io_port_in), .serial_in(serial_in));
  initial forever #5 sys_clk = ~sys_clk;
  task final_report;
    if (miscompares == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task chk(input string n, input logic [9:0] e, input logic [9:0] g);
    checks++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  // Write held over one taking edge
  task wr(input logic [1:0] s, input logic [9:0] d);
    @(posedge sys_clk);
    port_sel <= s;
    port_write <= 1'b1;
    port_wdata <= d;
    @(posedge sys_clk);
    port_write <= 1'b0;
  endtask
  // Read data lands one edge after the select
  task rd(input logic [1:0] s, output logic [9:0] q);
    @(posedge sys_clk);
    port_sel <= s;
    tick(1);
    q = port_rdata;
  endtask
  task halt(input logic [3:0] op);
    @(posedge sys_clk);
    halt_req <= {1'b1, op};
    @(posedge sys_clk);
    halt_req <= 5'h00;
    tick(2);
  endtask
  task aclr;
    all_clear_pin_n <= 1'b0;
    tick(6);
    chk("core_reset", 1, core_reset);
    all_clear_pin_n <= 1'b1;
    tick(5);
    chk("run", 1, exec_enable);
  endtask
  // A self reset may be short, so any sighting counts
  task seerst(input string n);
    logic hit;
    hit = 1'b0;
    repeat (10) begin
      tick(1);
      hit = hit | core_reset;
    end
    chk(n, 1, hit);
  endtask
  // Cuts a hang well past the expected length
  initial begin
    repeat (20000) @(posedge sys_clk);
    miscompares++;
    final_report;
  end
  initial begin
    logic [9:0] q;
    int c, e, i, r, h;
    e = $urandom(4974);
    repeat (20) @(posedge sys_clk);
    sys_rst <= 1'b0;
    tick(3);
    chk("indicator", 1, transmit_indicator);
    chk("serial_en", 0, serial_in_enable);
    chk("key_pd", 4'hf, key_pulldown);
    rd(kpc_pkg::PORT_CTRL, q);
    chk("ctrl_reset", 0, q & 10'h301);
    for (i = 0; i < 8; i++) begin
      c = $urandom & 63;
      wr(kpc_pkg::PORT_CTRL, 10'(c));
      rd(kpc_pkg::PORT_CTRL, q);
      chk("ctrl", 10'(c), q);
      chk("scan_oe", {8{c[1]}}, scan_io_port_oe);
      chk("scan_pd", {8{~c[1]}}, scan_io_port_pulldown);
      chk("timer_run", c[2], timer_run);
      chk("rom_ptr", c[5:4], rom_ptr_high);
      chk("serial_en", c[0], serial_in_enable);
      chk("serial_pd", c[0], serial_pulldown);
      e = $urandom & 255;
      press <= 8'(e);
      key_input_pins <= 4'(e >> 4);
      wr(kpc_pkg::PORT_SCAN, 10'(e));
      tick(3);
      rd(kpc_pkg::PORT_SCAN, q);
      chk("scan", 10'(e), q);
      rd(kpc_pkg::PORT_KEY, q);
      chk("key", 10'(e >> 4), q);
      r = $urandom & 31;
      ser_bit <= r[4];
      acc_in <= 4'(r);
      tick(3);
      rotate_left_instruction <= 1'b1;
      tick(1);
      rotate_left_instruction <= 1'b0;
      chk("rotate", {1'b1, r[2:0], c[0] ? r[4] : r[3]}, {acc_out_valid, acc_out});
    end
    wr(kpc_pkg::PORT_CTRL, 10'h002);
    key_input_pins <= 4'h0;
    tick(3);
    halt(4'ha);
    chk("halted", 0, exec_enable);
    wr(kpc_pkg::PORT_CTRL, 10'h006);
    key_input_pins <= 4'h2;
    tick(6);
    chk("key_wake", 1, exec_enable);
    rd(kpc_pkg::PORT_CTRL, q);
    chk("ctrl_kept", 10'h002, q);
    timer_nonzero <= 1'b1;
    halt(4'h3);
    chk("timer_hold", 0, exec_enable);
    timer_nonzero <= 1'b0;
    tick(4);
    chk("timer_wake", 1, exec_enable);
    halt(4'h0);
    tick(2);
    chk("serial_wake", 1, exec_enable);
    wr(kpc_pkg::PORT_CTRL, 10'h003);
    press <= 8'hff;
    halt(4'h9);
    tick(6);
    chk("scan_out_mode", 0, exec_enable);
    aclr;
    rd(kpc_pkg::PORT_CTRL, q);
    chk("ctrl_clear", 0, q & 10'h301);
    wr(kpc_pkg::PORT_CTRL, 10'h046);
    timer_nonzero <= 1'b1;
    key_input_pins <= 4'h0;
    halt(4'ha);
    tick(6);
    chk("osc_wait", 1, osc_running);
    chk("stopped", 0, exec_enable);
    timer_nonzero <= 1'b0;
    tick(4);
    chk("osc_stop", 0, osc_running);
    aclr;
    // Hang-up in stop, then an unused wake source in halt
    for (i = 0; i < 2; i++) begin
      mask_option <= i ? 10'h3d1 : 10'h3d8;
      wr(kpc_pkg::PORT_CTRL, i ? 10'h002 : 10'h040);
      key_input_pins <= 4'h0;
      tick(3);
      halt(4'ha);
      key_input_pins <= 4'(i);
      seerst(i ? "unused" : "hangup");
      tick(6);
    end
    mask_option <= 10'h3d0;
    timer_nonzero <= 1'b1;
    carrier_enable <= 1'b1;
    // Rising edges and high cycles over a common period
    for (i = 0; i < 3; i++) begin
      mask_option.third_duty <= (i == 2);
      wr(kpc_pkg::PORT_CTRL, i ? 10'h00e : 10'h006);
      tick(30);
      r = 0;
      h = 0;
      repeat (48) begin
        c = carrier_output;
        tick(1);
        r += (carrier_output && !c);
        h += carrier_output;
      end
      chk("rises", i ? 4 : 6, 10'(r));
      chk("highs", i == 2 ? 16 : 24, 10'(h));
      chk("tx_busy", 0, transmit_indicator);
    end
    timer_nonzero <= 1'b0;
    carrier_enable <= 1'b0;
    tick(6);
    chk("tx_idle", 1, transmit_indicator);
    low_voltage_reset <= 1'b1;
    tick(3);
    chk("lvr_ind", 0, transmit_indicator);
    low_voltage_reset <= 1'b0;
    tick(5);
    final_report;
  end
endmodule
